// ==== rsc_pkg.sv ====
// Constants, field layout and config carrier for reference input selection
package rsc_pkg;

    // Register offsets on the configuration port
    localparam logic [7:0] ADDR_PRIORITY = 8'h14;
    localparam logic [7:0] ADDR_MODE     = 8'h15;
    localparam logic [7:0] ADDR_HOLDOFF  = 8'h16;
    localparam logic [7:0] ADDR_MONITOR  = 8'h17;

    // Field positions, priority register
    localparam int PRIO0_LSB = 6;
    localparam int PRIO1_LSB = 4;

    // Field positions, mode register
    localparam int LOSS_BLOCK_BIT = 6;
    localparam int PREDIV_BIT     = 5;
    localparam int REVERTIVE_SWITCH_ENABLE_BIT       = 4;
    localparam int MODE_LSB       = 2;
    localparam int SEL_LSB        = 0;

    // Field positions, monitor register
    localparam int PRESCALE_LSB  = 6;
    localparam int POWERDOWN_LSB = 2;
    localparam int COUNTER_LSB   = 0;

    // Reset values
    localparam logic [1:0] PRIO0_RST    = 2'h3;
    localparam logic [1:0] PRIO1_RST    = 2'h2;
    localparam logic [1:0] MODE_RST     = 2'h0;
    localparam logic [1:0] SEL_RST      = 2'h0;
    localparam logic       PREDIV_RST   = 1'h0;
    localparam logic       REVERTIVE_SWITCH_ENABLE_RST     = 1'h0;
    localparam logic       LOSS_BLK_RST = 1'h0;
    localparam logic [7:0] HOLDOFF_RST  = 8'h80;
    localparam logic [1:0] FIELD2_RST   = 2'h0;

    // Manual select codes and pre-divider count
    localparam logic [1:0] SEL_IN0      = 2'h0;
    localparam logic [1:0] SEL_IN1      = 2'h1;
    localparam logic [1:0] PREDIV_LAST  = 2'h3;
    localparam logic [1:0] ONE2         = 2'h1;
    localparam logic [7:0] ZERO8        = 8'h00;

    // Selection mode codes; low bit set means automatic selection
    typedef enum logic [1:0] {
        RSC_MODE_MANUAL   = 2'b00,
        RSC_MODE_AUTO     = 2'b01,
        RSC_MODE_SHORT_HO = 2'b10,
        RSC_MODE_AUTO_HO  = 2'b11
    } rsc_mode_t;

    // Full configuration image
    typedef struct packed {
        logic [1:0] prio0;
        logic [1:0] prio1;
        logic       loss_block_enable;
        logic       monitor_prediv_select;
        logic       revertive_switch_enable;
        rsc_mode_t  selection_mode;
        logic [1:0] manual_select;
        logic [7:0] holdoff_count;
        logic [1:0] holdoff_prescale;
        logic [1:0] input_powerdown;
        logic [1:0] activity_monitor_counter;
    } rsc_cfg_t;

endpackage

// ==== rsc_prediv.sv ====
// Activity monitor pre-divider for one reference input
`timescale 1ns/100ps
`default_nettype none
module rsc_prediv (
    // Clock and reset
    input  wire logic clock,
    input  wire logic rst,
    // Monitored input edge and divider choice
    input  wire logic edge_in,
    input  wire logic div4,
    // Divided activity tick
    output logic      tick
);
    logic [1:0] count;
    wire        wrap = (count == rsc_pkg::PREDIV_LAST);
    wire        pass = edge_in & (~div4 | wrap);

    // Count edges; counter idles at zero while dividing by one
    always_ff @(posedge clock) begin
        if (rst) begin
            count <= 2'h0;
            tick  <= 1'b0;
        end else begin
            if (edge_in && div4) begin
                count <= count + rsc_pkg::ONE2;
            end else if (!div4) begin
                count <= 2'h0;
            end
            tick <= pass;
        end
    end
endmodule // rsc_prediv
`default_nettype wire

// ==== rsc_select.sv ====
// Reference input selection registers and active reference choice
// Notes on behaviour
// - Each input has a two-bit priority, 11 highest, resetting to 11 for input 0 and 10 for 1.
// - On equal priority automatic selection keeps the current input and does not move to input 0.
// - The monitor pre-divider select divides by one when clear and by four when set, reset 0.
// - With revertive switching off, revalidation of an unselected input keeps the selection.
// - Revertive switching acts only in automatic modes and is ignored in manual mode.
// - In manual mode select code 00 picks input 0 and code 01 picks input 1.
// - In automatic modes (mode low bit one) the manual select field has no effect.
`timescale 1ns/100ps
`default_nettype none
module rsc_select (
    // Clock and reset
    input  wire logic            clock,
    input  wire logic            rst,
    // Register port from the serial front end
    input  wire logic            wr_en,
    input  wire logic            rd_en,
    input  wire logic [7:0]      addr,
    input  wire logic [7:0]      wdata,
    output logic      [7:0]      rdata,
    // Reference status and activity
    input  wire logic [1:0]      ref_valid,
    input  wire logic [1:0]      ref_edge,
    // Selection results
    output logic                 active_ref,
    output logic                 holdover,
    output logic      [1:0]      monitor_tick,
    output rsc_pkg::rsc_cfg_t    cfg
);
    // Address decode
    wire hit_prio = (addr == rsc_pkg::ADDR_PRIORITY);
    wire hit_mode = (addr == rsc_pkg::ADDR_MODE);
    wire hit_hold = (addr == rsc_pkg::ADDR_HOLDOFF);
    wire hit_mon  = (addr == rsc_pkg::ADDR_MONITOR);

    // Readback words; reserved positions are constant zero
    wire [7:0] rd_prio = {cfg.prio0, cfg.prio1, 4'h0};
    wire [7:0] rd_mode = {1'b0, cfg.loss_block_enable, cfg.monitor_prediv_select,
                          cfg.revertive_switch_enable, cfg.selection_mode,
                          cfg.manual_select};
    wire [7:0] rd_mon  = {cfg.holdoff_prescale, 2'h0, cfg.input_powerdown,
                          cfg.activity_monitor_counter};
    wire [7:0] rd_word = hit_prio ? rd_prio :
                         hit_mode ? rd_mode :
                         hit_hold ? cfg.holdoff_count :
                         hit_mon  ? rd_mon : rsc_pkg::ZERO8;

    // Register writes; reserved bits are never stored
    always_ff @(posedge clock) begin
        if (rst) begin
            cfg.prio0                    <= rsc_pkg::PRIO0_RST;
            cfg.prio1                    <= rsc_pkg::PRIO1_RST;
            cfg.loss_block_enable        <= rsc_pkg::LOSS_BLK_RST;
            cfg.monitor_prediv_select    <= rsc_pkg::PREDIV_RST;
            cfg.revertive_switch_enable  <= rsc_pkg::REVERTIVE_SWITCH_ENABLE_RST;
            cfg.selection_mode           <= rsc_pkg::RSC_MODE_MANUAL;
            cfg.manual_select            <= rsc_pkg::SEL_RST;
            cfg.holdoff_count            <= rsc_pkg::HOLDOFF_RST;
            cfg.holdoff_prescale         <= rsc_pkg::FIELD2_RST;
            cfg.input_powerdown          <= rsc_pkg::FIELD2_RST;
            cfg.activity_monitor_counter <= rsc_pkg::FIELD2_RST;
        end else if (wr_en) begin
            if (hit_prio) begin
                cfg.prio0 <= wdata[rsc_pkg::PRIO0_LSB +: 2];
                cfg.prio1 <= wdata[rsc_pkg::PRIO1_LSB +: 2];
            end
            if (hit_mode) begin
                cfg.loss_block_enable       <= wdata[rsc_pkg::LOSS_BLOCK_BIT];
                cfg.monitor_prediv_select   <= wdata[rsc_pkg::PREDIV_BIT];
                cfg.revertive_switch_enable <= wdata[rsc_pkg::REVERTIVE_SWITCH_ENABLE_BIT];
                cfg.selection_mode          <= rsc_pkg::rsc_mode_t'(wdata[rsc_pkg::MODE_LSB +: 2]);
                cfg.manual_select           <= wdata[rsc_pkg::SEL_LSB +: 2];
            end
            if (hit_hold) begin
                cfg.holdoff_count <= wdata;
            end
            if (hit_mon) begin
                cfg.holdoff_prescale         <= wdata[rsc_pkg::PRESCALE_LSB +: 2];
                cfg.input_powerdown          <= wdata[rsc_pkg::POWERDOWN_LSB +: 2];
                cfg.activity_monitor_counter <= wdata[rsc_pkg::COUNTER_LSB +: 2];
            end
        end
    end

    // Registered readback; unmapped addresses answer zero
    always_ff @(posedge clock) begin
        if (rst) begin
            rdata <= rsc_pkg::ZERO8;
        end else if (rd_en) begin
            rdata <= rd_word;
        end
    end

    // Best valid input by priority, input 0 winning ties
    wire       auto_mode = cfg.selection_mode[0];
    wire       best_sel  = ~(ref_valid[0] & (~ref_valid[1] | (cfg.prio0 >= cfg.prio1)));
    wire [1:0] best_prio = best_sel ? cfg.prio1 : cfg.prio0;
    wire [1:0] cur_prio  = active_ref ? cfg.prio1 : cfg.prio0;
    wire       any_valid = |ref_valid;
    wire       cur_ok    = ref_valid[active_ref];
    // Revert only on strictly higher priority, so equal inputs never ping-pong
    wire       revert    = cfg.revertive_switch_enable & (best_prio > cur_prio);
    wire       manual_pick = (cfg.manual_select == rsc_pkg::SEL_IN1);
    wire       auto_pick = (!any_valid || (cur_ok && !revert)) ? active_ref : best_sel;
    wire       next_active   = auto_mode ? auto_pick : manual_pick;
    wire       next_holdover = auto_mode & ~any_valid;

    // Active reference register; holdover keeps the last choice
    always_ff @(posedge clock) begin
        if (rst) begin
            active_ref <= 1'b0;
            holdover   <= 1'b0;
        end else begin
            active_ref <= next_active;
            holdover   <= next_holdover;
        end
    end

    // One pre-divider per monitored input
    genvar gi;
    generate
        for (gi = 0; gi < 2; gi = gi + 1) begin : g_prediv
            rsc_prediv u_prediv (
                .clock   (clock),
                .rst     (rst),
                .edge_in (ref_edge[gi]),
                .div4    (cfg.monitor_prediv_select),
                .tick    (monitor_tick[gi])
            );
        end
    endgenerate

    // Checks on the selection behaviour
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    property p_prio_reset;
        $past(rst) |-> (cfg.prio0 == rsc_pkg::PRIO0_RST) && (cfg.prio1 == rsc_pkg::PRIO1_RST);
    endproperty
    a_prio_reset: assert property (p_prio_reset) else $error("priority reset wrong");

    property p_tie_input0;
        (auto_mode && ref_valid == 2'b11 && cfg.prio0 == cfg.prio1) |-> !best_sel;
    endproperty
    a_tie_input0: assert property (p_tie_input0) else $error("tie not to input 0");

    property p_div1_pass;
        (!cfg.monitor_prediv_select && ref_edge[0]) |=> monitor_tick[0];
    endproperty
    a_div1_pass: assert property (p_div1_pass) else $error("divide by one lost edge");

    property p_div4_gap;
        (cfg.monitor_prediv_select && monitor_tick[0]) |=> !monitor_tick[0] [*3];
    endproperty
    a_div4_gap: assert property (p_div4_gap) else $error("divide by four too fast");

    property p_no_revert;
        (auto_mode && !cfg.revertive_switch_enable && ref_valid[active_ref])
            |=> $stable(active_ref);
    endproperty
    a_no_revert: assert property (p_no_revert) else $error("switched without revert");

    property p_manual_in0;
        (!auto_mode && cfg.manual_select == rsc_pkg::SEL_IN0) |=> !active_ref && !holdover;
    endproperty
    a_manual_in0: assert property (p_manual_in0) else $error("manual 00 wrong");

    property p_manual_in1;
        (!auto_mode && cfg.manual_select == rsc_pkg::SEL_IN1) |=> active_ref;
    endproperty
    a_manual_in1: assert property (p_manual_in1) else $error("manual 01 wrong");

    property p_auto_ignores_sel;
        (auto_mode && ref_valid == 2'b01) |=> !active_ref;
    endproperty
    a_auto_ignores_sel: assert property (p_auto_ignores_sel) else $error("auto used sel");

    property p_reserved_zero;
        (rd_en && hit_prio) |=> (rdata[3:0] == 4'h0);
    endproperty
    a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bits set");

    property p_reserved_mode;
        (rd_en && hit_mode) |=> !rdata[7];
    endproperty
    a_reserved_mode: assert property (p_reserved_mode) else $error("mode bit 7 set");

    property p_mode_reset;
        $past(rst) |-> (cfg.monitor_prediv_select == rsc_pkg::PREDIV_RST) &&
                       (cfg.revertive_switch_enable == rsc_pkg::REVERTIVE_SWITCH_ENABLE_RST);
    endproperty
    a_mode_reset: assert property (p_mode_reset) else $error("mode reset wrong");

    // Second monitor channel, so a broken generate index shows up
    property p_div1_pass1;
        (!cfg.monitor_prediv_select && ref_edge[1]) |=> monitor_tick[1];
    endproperty
    a_div1_pass1: assert property (p_div1_pass1) else $error("div1 lost edge 1");

    property p_tick_needs_edge;
        !ref_edge[0] |=> !monitor_tick[0];
    endproperty
    a_tick_needs_edge: assert property (p_tick_needs_edge) else $error("stray tick");

    property p_revert_up;
        (auto_mode && cfg.revertive_switch_enable && ref_valid == 2'h3 && active_ref &&
         cfg.prio0 > cfg.prio1) |=> !active_ref;
    endproperty
    a_revert_up: assert property (p_revert_up) else $error("no revert to higher");

    property p_auto_in1_only;
        (auto_mode && ref_valid == 2'h2) |=> active_ref;
    endproperty
    a_auto_in1_only: assert property (p_auto_in1_only) else $error("auto used sel 1");

    // Codes 10 and 11 fall back to input 0 rather than holding a stale choice
    property p_manual_sel_hi;
        (!auto_mode && cfg.manual_select[1]) |=> !active_ref;
    endproperty
    a_manual_sel_hi: assert property (p_manual_sel_hi) else $error("manual 1x wrong");

    c_revert: cover property (auto_mode && revert && cur_ok ##1 $changed(active_ref));
    c_holdover: cover property (auto_mode && !any_valid ##1 holdover);
    c_failover: cover property (auto_mode && !cur_ok && any_valid ##1 $changed(active_ref));
    c_div4_tick: cover property (cfg.monitor_prediv_select && monitor_tick[1]);
endmodule // rsc_select
`default_nettype wire

// ==== tb_reference_input_selection_config.sv ====
// Self-checking bench for the reference input selection registers
`timescale 1ns/100ps
`default_nettype none
module tb_reference_input_selection_config;
    logic              clock;
    logic              rst;
    logic              wr_en;
    logic              rd_en;
    logic [7:0]        addr;
    logic [7:0]        wdata;
    logic [7:0]        rdata;
    logic [1:0]        ref_valid;
    logic [1:0]        ref_edge;
    logic              active_ref;
    logic              holdover;
    logic [1:0]        monitor_tick;
    rsc_pkg::rsc_cfg_t cfg;
    int                fail_count;
    int                n_compared;
    int                ticks;
    int                ticks1;

    rsc_select dut (.clock(clock), .rst(rst), .wr_en(wr_en), .rd_en(rd_en), .addr(addr),
        .wdata(wdata), .rdata(rdata), .ref_valid(ref_valid), .ref_edge(ref_edge),
        .active_ref(active_ref), .holdover(holdover), .monitor_tick(monitor_tick), .cfg(cfg));

    // Free-running 8 ns clock
    initial begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end

    // Compare and count
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            fail_count++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // Write; extra idle cycle so back-to-back strobes never change in one step
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        addr = a;
        wdata = d;
        wr_en = 1'b1;
        @(negedge clock);
        wr_en = 1'b0;
        @(negedge clock);
    endtask

    // Read; rdata is registered, settled by the next falling edge
    task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string what);
        addr = a;
        rd_en = 1'b1;
        @(negedge clock);
        rd_en = 1'b0;
        check(what, rdata, exp);
        @(negedge clock);
    endtask

    // Set reference status, let selection settle, check chosen input
    task automatic sel(input logic [1:0] v, input logic exp, input string what);
        ref_valid = v;
        repeat (3) @(negedge clock);
        check(what, {7'h0, active_ref}, {7'h0, exp});
    endtask

    // Back-to-back activity pulses on both inputs, ticks counted during the pulses and over a trailing window
    task automatic edges(input int n, input int win, output int cnt0, output int cnt1);
        cnt0 = 0;
        cnt1 = 0;
        ref_edge = 2'h3;
        repeat (n) begin
            @(negedge clock);
            cnt0 += int'(monitor_tick[0] === 1'b1);
            cnt1 += int'(monitor_tick[1] === 1'b1);
        end
        ref_edge = 2'h0;
        repeat (win) begin
            @(negedge clock);
            cnt0 += int'(monitor_tick[0] === 1'b1);
            cnt1 += int'(monitor_tick[1] === 1'b1);
        end
    endtask

    task automatic test_reset;
        rd(8'h14, 8'he0, "prio reset");
        rd(8'h15, 8'h00, "mode reset");
        rd(8'h16, 8'h80, "holdoff reset");
        rd(8'h17, 8'h00, "monitor reset");
    endtask

    // Reserved bits and an unmapped address
    task automatic test_reserved;
        wr(8'h14, 8'hff);
        check("cfg prio", {cfg.prio0, cfg.prio1, 4'h0}, 8'hf0);
        rd(8'h14, 8'hf0, "prio reserved");
        wr(8'h15, 8'hff);
        rd(8'h15, 8'h7f, "mode reserved");
        wr(8'h17, 8'hff);
        rd(8'h17, 8'hcf, "monitor reserved");
        wr(8'h20, 8'hff);
        rd(8'h20, 8'h00, "unmapped");
        wr(8'h16, 8'h5a);
        rd(8'h16, 8'h5a, "holdoff rw");
        check("cfg holdoff", cfg.holdoff_count, 8'h5a);
        wr(8'h14, 8'he0);
        wr(8'h17, 8'h00);
    endtask

    // Manual mode follows the select code, even with no valid input
    task automatic test_manual;
        wr(8'h15, 8'h01);
        sel(2'b00, 1'b1, "manual sel 01");
        wr(8'h15, 8'h00);
        sel(2'b00, 1'b0, "manual sel 00");
        wr(8'h15, 8'h11);
        sel(2'b11, 1'b1, "manual revertive_switch_enable ignored");
        wr(8'h15, 8'h03);
        sel(2'h3, 1'b0, "manual sel 11");
        wr(8'h15, 8'h09);
        sel(2'h0, 1'b1, "mode 10 is manual");
    endtask

    // Automatic mode: failover, revertive switching and equal priority
    task automatic test_auto;
        wr(8'h15, 8'h00);
        sel(2'b01, 1'b0, "manual start");
        wr(8'h15, 8'h05);
        sel(2'b01, 1'b0, "auto ignores sel");
        sel(2'b10, 1'b1, "auto failover");
        sel(2'b11, 1'b1, "no revert");
        wr(8'h15, 8'h15);
        sel(2'b11, 1'b0, "revert to higher");
        wr(8'h14, 8'h00);
        sel(2'b10, 1'b1, "equal prio failover");
        sel(2'b11, 1'b1, "equal prio no revert");
        sel(2'b00, 1'b1, "hold last");
        check("holdover", {7'h0, holdover}, 8'h01);
        wr(8'h14, 8'he0);
    endtask

    // Monitor pre-divider by one then by four
    task automatic test_prediv;
        wr(8'h15, 8'h00);
        edges(1, 3, ticks, ticks1);
        check("div1 ticks", 8'(ticks), 8'h01);
        check("div1 ticks 1", 8'(ticks1), 8'h01);
        wr(8'h15, 8'h20); // fast inputs take divide by four
        edges(3, 2, ticks, ticks1);
        check("div4 early", 8'(ticks), 8'h00);
        check("div4 early 1", 8'(ticks1), 8'h00);
        edges(1, 3, ticks, ticks1);
        check("div4 fourth", 8'(ticks), 8'h01);
        check("div4 fourth 1", 8'(ticks1), 8'h01);
    endtask

    // Verdict and end of run
    task automatic tally_and_finish;
        $display("compared %0d mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // Main sequence; every wait is a fixed count
    initial begin
        fail_count = 0;
        n_compared = 0;
        rst = 1'b1;
        wr_en = 1'b0;
        rd_en = 1'b0;
        addr = 8'h00;
        wdata = 8'h00;
        ref_valid = 2'b00;
        ref_edge = 2'b00;
        repeat (3) @(negedge clock);
        rst = 1'b0;
        test_reset();
        test_reserved();
        test_manual();
        test_auto();
        test_prediv();
        tally_and_finish();
    end
endmodule // tb_reference_input_selection_config
`default_nettype wire
